/* bench/mcct_checker.sv */
`timescale 1ns/100ps
// protocol and event checks seen from the block's ports
module mcct_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  channel_irq,
  input wire logic        timer_irq,
  input wire logic [3:0]  dma_ack,
  input wire logic [3:0]  dma_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus handshake: one access cycle, then released
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("pready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
  a_rdata_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  // events are single-cycle request pulses
  a_timer_irq_pulse: assert property (timer_irq |=> !timer_irq) else $error("timer_irq too long");
  a_ch_irq_pulse: assert property (|channel_irq |=> (channel_irq & $past(channel_irq)) == 4'h0)
    else $error("channel_irq too long");
  // a channel 0 dma request only follows a channel 0 event, and an ack withdraws it
  a_dma_has_cause: assert property ($rose(dma_req[0]) |-> channel_irq[0] || $past(channel_irq[0]))
    else $error("dma_req without event");
  // a fresh event in the ack cycle renews the request
  a_dma_ack_clears: assert property (dma_ack[0] && !channel_irq[0] && !$past(channel_irq[0])
    |=> !dma_req[0] || channel_irq[0]) else $error("dma_req kept after ack");
endmodule // mcct_checker

bind mcct_top mcct_checker u_chk (
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .channel_irq (channel_irq),
  .timer_irq   (timer_irq),
  .dma_ack     (dma_ack),
  .dma_req     (dma_req)
);

/* bench/mcct_partner.sv */
`timescale 1ns/100ps
// pins, event lines and dma engine around the timer
module mcct_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ext_en,
  input  wire logic [3:0] cap_lvl,
  input  wire logic [3:0] cap_ev,
  input  wire logic [3:0] dma_req,
  output wire logic       timer_input_pin,
  output wire logic       ev_timer_input,
  output wire logic [3:0] channel_in_pin,
  output wire logic [3:0] ev_channel_input,
  output wire logic [3:0] dma_ack
);
  logic [1:0] div_ff;
  logic       ext_ff;
  logic [3:0] seen_ff;
  logic [3:0] ack_ff;

  // external clock at an eighth of pclk, frozen while disabled
  // dma answers slowly, two cycles after the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
      ext_ff <= 1'b0;
      seen_ff <= 4'h0;
      ack_ff <= 4'h0;
    end else begin
      div_ff <= ext_en ? div_ff + 2'h1 : 2'h0;
      if (ext_en && div_ff == 2'h3) ext_ff <= ~ext_ff;
      seen_ff <= dma_req & ~ack_ff;
      ack_ff <= seen_ff & dma_req & ~ack_ff;
    end
  end

  // unused event source stays low
  assign timer_input_pin = ext_ff;
  assign ev_timer_input = 1'b0;
  assign channel_in_pin = cap_lvl;
  assign ev_channel_input = cap_ev;
  assign dma_ack = ack_ff;
endmodule // mcct_partner

/* bench/tb_top.sv */
`timescale 1ns/100ps
`include "mcct_defs.vh"
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ext_en = 1'b0;
  logic [3:0]  cap_lvl = 4'h0;
  logic [3:0]  cap_ev = 4'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, timer_irq, tin_pin, tin_ev;
  wire  [3:0]  ch_pin, ch_ev, dma_ack, channel_output, channel_irq, dma_req;
  logic [32:0] expq[$];
  logic [31:0] src[4], rl[4], md[4], dv[4], ep[4];
  logic        o;
  int          error_cnt = 0, num_checks = 0, n, code;

  always #4 pclk = ~pclk;

  mcct_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_pin(tin_pin), .ev_timer_input(tin_ev), .channel_in_pin(ch_pin), .ev_channel_input(ch_ev),
    .dma_ack(dma_ack), .channel_output(channel_output), .channel_irq(channel_irq), .timer_irq(timer_irq),
    .dma_req(dma_req));
  mcct_partner pm (.pclk(pclk), .presetn(presetn), .ext_en(ext_en), .cap_lvl(cap_lvl), .cap_ev(cap_ev),
    .dma_req(dma_req), .timer_input_pin(tin_pin), .ev_timer_input(tin_ev), .channel_in_pin(ch_pin),
    .ev_channel_input(ch_ev), .dma_ack(dma_ack));

  task summarize;
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask
  task fail_to;
    error_cnt++;
    $display("Error at %0t: wait timed out", $time);
    summarize;
  endtask
  // one transfer, then an idle cycle so no signal is driven twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    if (!w) expq.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    i = 0;
    // pready is sampled at the rising edge that completes the access
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) fail_to;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  // cycles until the next event pulse (k 4 is the timer), output bit seen with it
  task wait_ev(input int k, output int cnt, output logic ob);
    cnt = 0;
    do begin
      @(negedge pclk);
      cnt++;
    end while ((k == 4 ? timer_irq : channel_irq[k]) !== 1'b1 && cnt < 3000);
    if (cnt >= 3000) fail_to;
    ob = channel_output[k % 4];
    @(posedge pclk);
  endtask

  // read completions checked against the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) chk(1'b0);
      else chk({pslverr, prdata} === expq.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_to;
  end

  initial begin
    code = $urandom(32'h2fd59780);
    code = $urandom % 3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped holes and a misaligned access
    for (int a = 0; a < 64; a += 4) rd(8'(a), {1'(a >= 20 && a < 32), 32'h0});
    rd(8'h06, {1'b1, 32'h0});
    // clock sources, divide factors and both count modes
    src = '{0, 0, 1, 2};
    rl = '{2, 3, 3, 1};
    md = '{0, 2, 0, 0};
    dv = '{code, 0, 0, 7};
    ep = '{3 << code, 6, 8, 16};
    for (int i = 0; i < 4; i++) begin
      wr(`MCCT_A_CTRL1, 32'h0);
      wr(`MCCT_A_COUNT, 32'h0);
      ext_en <= (src[i] != 0);
      wr(`MCCT_A_CTRL0, src[i]);
      wr(`MCCT_A_RELOAD, rl[i]);
      wr(`MCCT_A_CTRL1, 32'h80 | md[i] << 4 | dv[i]);
      rd(`MCCT_A_CTRL1, {1'b0, 32'h80 | md[i] << 4 | dv[i]});
      repeat (3) wait_ev(4, n, o);
      chk(n == ep[i]);
    end
    // reload zero halts at zero, nonzero resumes
    wr(`MCCT_A_CTRL0, 32'h0);
    wr(`MCCT_A_RELOAD, 32'h0);
    repeat (30) @(posedge pclk);
    rd(`MCCT_A_COUNT, {1'b0, 32'h0});
    wr(`MCCT_A_RELOAD, 32'h2);
    repeat (2) wait_ev(4, n, o);
    chk(n == 384); // divide by 128 from the last source test still applies
    // reserved mode holds, modulo above reload restarts at zero
    wr(`MCCT_A_CTRL1, 32'h0);
    wr(`MCCT_A_COUNT, 32'h5);
    wr(`MCCT_A_CTRL1, 32'h90);
    repeat (10) @(posedge pclk);
    rd(`MCCT_A_COUNT, {1'b0, 32'h5});
    wr(`MCCT_A_CTRL1, 32'h80);
    wait_ev(4, n, o);
    chk(n < 8);
    // continuous compare, polarity set before enable
    wr(`MCCT_A_CHVAL, 32'h1);
    wr(`MCCT_A_CHCTL, 32'h4);
    wr(`MCCT_A_CHCTL, 32'h5);
    repeat (2) wait_ev(0, n, o);
    chk(n == 3 && o === 1'b1);
    wr(`MCCT_A_CHCTL, 32'h0);
    // one-shot, inverted polarity
    wr(8'h34, 32'h2);
    wr(8'h24, 32'h2);
    wr(8'h24, 32'h3);
    wait_ev(1, n, o);
    chk(o === 1'b0);
    rd(8'h24, {1'b0, 32'h2});
    // pwm high from match until the wrap
    wr(8'h3c, 32'h1);
    wr(8'h2c, 32'h8);
    wr(8'h2c, 32'h9);
    wait_ev(3, n, o);
    // the pwm level follows its event pulse by one cycle
    @(negedge pclk);
    o = channel_output[3];
    n = 0;
    while (channel_output[3] === 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    chk(o === 1'b1 && n == 2);
    // capture on rising pin edge, then falling event edge
    wr(`MCCT_A_CTRL1, 32'h0);
    wr(`MCCT_A_COUNT, 32'h1234);
    wr(8'h28, 32'hc);
    wr(8'h28, 32'hd);
    cap_lvl[2] <= 1'b1;
    wait_ev(2, n, o);
    rd(8'h38, {1'b0, 32'h1234});
    cap_lvl[2] <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(`MCCT_A_COUNT, 32'h4321);
    wr(8'h28, 32'he);
    wr(8'h28, 32'hf);
    cap_ev[2] <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(8'h38, {1'b0, 32'h1234});
    cap_ev[2] <= 1'b0;
    wait_ev(2, n, o);
    rd(8'h38, {1'b0, 32'h4321});
    summarize;
  end
endmodule // tb_top

/* shared/mcct_defs.vh */
`ifndef MCCT_DEFS_VH
`define MCCT_DEFS_VH

// register byte offsets
`define MCCT_A_CTRL0      8'h00
`define MCCT_A_CTRL1      8'h04
`define MCCT_A_COUNT      8'h08
`define MCCT_A_RELOAD     8'h0c
`define MCCT_A_STATUS     8'h10
`define MCCT_A_CHCTL      8'h20
`define MCCT_A_CHVAL      8'h30
`define MCCT_A_STRIDE     8'h04

// timer_control_zero fields
`define MCCT_CLKSRC_HI    1
`define MCCT_CLKSRC_LO    0
`define MCCT_SRC_SYS      2'h0
`define MCCT_SRC_GATED    2'h1
`define MCCT_SRC_EXT      2'h2

// timer_control_one fields
`define MCCT_RUN_BIT      7
`define MCCT_MODE_HI      5
`define MCCT_MODE_LO      4
`define MCCT_DIV_HI       2
`define MCCT_DIV_LO       0
`define MCCT_MODE_MOD     2'h0
`define MCCT_MODE_UPDN    2'h2

// channel control fields
`define MCCT_CH_ON        0
`define MCCT_CH_POL       1
`define MCCT_CH_MHI       3
`define MCCT_CH_MLO       2
`define MCCT_CM_ONESHOT   2'h0
`define MCCT_CM_CONT      2'h1
`define MCCT_CM_PWM       2'h2
`define MCCT_CM_CAPT      2'h3

// status fields
`define MCCT_ST_TIMER     4
`define MCCT_ST_DMA_LO    8

// widths and reset values
`define MCCT_CW           16
`define MCCT_NCH          4
`define MCCT_PW           7
`define MCCT_ZERO16       16'h0000
`define MCCT_ONE16        16'h0001
`define MCCT_ZERO32       32'h00000000

`endif

/* src/mcct_sync.v */
`timescale 1ns/100ps
`include "mcct_defs.vh"

// two-stage synchroniser bank for pin and event-system inputs
module mcct_sync #(
  parameter W = 10
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] stab_ff;

  // first stage feeds only the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {W{1'b0}};
      stab_ff <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      stab_ff <= meta_ff;
    end
  end

  assign dout = stab_ff;

endmodule // mcct_sync

/* src/mcct_top.v */
`timescale 1ns/100ps
`include "mcct_defs.vh"

// Function
// - 16-bit counter steps up or down on each selected timer clock tick.
// - every timer input is pin input ORed with its event-system signal.
// - clock source: system clock, gated system clock, or external input.
// - 3-bit divide field divides system clock by 1 to 128.
// - divide field is buffered; applied at once while stopped, else at end of counting cycle.
// - external input clock bypasses the prescaler.
// - counting only while run enable set and clock source active.
// - reload zero halts counter at zero; nonzero reload resumes.
// - mode 00 is modulo, 10 up/down, 01 and 11 reserved.
// - modulo counts to reload then wraps to zero, with timer event.
// - modulo selected above reload restarts counter from zero at once while running; a stopped count is kept.
// - up/down counts to reload and back to zero, event at zero.
// - compare writes while running take effect at end of cycle.
// - four channels: one-shot, continuous, PWM or capture each.
// - one-shot match flags, interrupts and disables the channel.
// - one-shot output pulses away from idle for one clock.
// - continuous match flags, interrupts and pulses; channel stays on.
// - PWM output starts at polarity, flips on match, flags and interrupts.
// - PWM returns to polarity on modulo wrap or down-count match.
// - capture copies count on chosen input edge, flags and interrupts.
// - channel event raises DMA request, dropped on ack or disable.
module mcct_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        timer_input_pin,
  input  wire        ev_timer_input,
  input  wire [3:0]  channel_in_pin,
  input  wire [3:0]  ev_channel_input,
  input  wire [3:0]  dma_ack,
  output reg  [3:0]  channel_output,
  output reg  [3:0]  channel_irq,
  output reg         timer_irq,
  output reg  [3:0]  dma_req
);

  // control and status state
  reg  [1:0]  clock_source_select_ff;
  reg         timer_run_enable_ff;
  reg  [1:0]  count_mode_select_ff;
  reg  [2:0]  div_buf_ff;
  reg  [2:0]  div_act_ff;
  reg  [15:0] count_ff;
  reg  [15:0] reload_ff;
  reg         down_ff;
  reg  [6:0]  pre_cnt_ff;
  reg         ext_prev_ff;
  reg         step_d_ff;
  reg         timer_flag_ff;
  reg  [3:0]  channel_event_flag_ff;
  reg  [3:0]  channel_on_ff;
  reg  [3:0]  channel_polarity_ff;
  reg  [7:0]  ch_mode_ff;
  reg  [63:0] cmp_buf_ff;
  reg  [63:0] cmp_act_ff;
  reg  [3:0]  pwm_lvl_ff;
  reg  [3:0]  cin_prev_ff;

  wire [9:0]  sync_out;
  wire        external_timer_input;
  wire [3:0]  ch_in;

  // every input crosses two flops before the OR
  mcct_sync #(.W(10)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({ev_channel_input, channel_in_pin, ev_timer_input, timer_input_pin}),
    .dout    (sync_out)
  );

  // unused source is held low outside, so OR merges cleanly
  assign external_timer_input = sync_out[0] | sync_out[1];
  assign ch_in = sync_out[5:2] | sync_out[9:6];

  // mask of low prescaler bits for a divide code
  function [6:0] div_mask;
    input [2:0] code;
    begin
      div_mask = (7'h01 << code) - 7'h01;
    end
  endfunction

  // register index decode for channel windows
  function [1:0] ch_idx;
    input [7:0] a;
    begin
      ch_idx = a[3:2];
    end
  endfunction

  // apb phase terms
  wire       setup  = psel & ~penable;
  wire       wr_acc = psel & penable & pready & pwrite & ~pslverr;  // refused writes land nowhere
  wire [1:0] widx   = ch_idx(paddr);
  wire       wr_ctl = wr_acc && (paddr & 8'hf0) == `MCCT_A_CHCTL;
  wire       wr_val = wr_acc && (paddr & 8'hf0) == `MCCT_A_CHVAL;

  // tick generation
  wire pre_tick = (pre_cnt_ff & div_mask(div_act_ff)) == div_mask(div_act_ff);
  wire ext_rise = external_timer_input & ~ext_prev_ff;
  reg  src_tick;

  always @* begin
    case (clock_source_select_ff)
      `MCCT_SRC_SYS:   src_tick = pre_tick;
      `MCCT_SRC_GATED: src_tick = pre_tick & external_timer_input;
      `MCCT_SRC_EXT:   src_tick = ext_rise;
      default:         src_tick = 1'b0;
    endcase
  end

  // external clock edges are only seen if no faster than pclk/2
  wire mode_ok = count_mode_select_ff == `MCCT_MODE_MOD || count_mode_select_ff == `MCCT_MODE_UPDN;
  wire halted  = reload_ff == `MCCT_ZERO16 && count_ff == `MCCT_ZERO16;
  wire step    = timer_run_enable_ff & src_tick & mode_ok & ~halted;
  wire is_mod  = count_mode_select_ff == `MCCT_MODE_MOD;
  wire over    = timer_run_enable_ff && is_mod && count_ff > reload_ff;  // stopped count is kept

  // next count and end-of-cycle detection
  reg [15:0] nxt_count;
  reg        nxt_down;
  reg        eoc;

  always @* begin
    nxt_count = count_ff;
    nxt_down  = down_ff;
    eoc       = 1'b0;
    if (is_mod) begin
      if (count_ff >= reload_ff) begin
        nxt_count = `MCCT_ZERO16;
        eoc       = 1'b1;
      end else begin
        nxt_count = count_ff + `MCCT_ONE16;
      end
    end else if (!down_ff) begin
      if (count_ff >= reload_ff) begin
        nxt_count = count_ff - `MCCT_ONE16;
        nxt_down  = 1'b1;
        eoc       = count_ff == `MCCT_ONE16;  // reload 1 turns at one, so this step ends the cycle
      end else begin
        nxt_count = count_ff + `MCCT_ONE16;
      end
    end else begin
      if (count_ff == `MCCT_ZERO16) begin
        nxt_count = count_ff + `MCCT_ONE16;
        nxt_down  = 1'b0;
      end else begin
        nxt_count = count_ff - `MCCT_ONE16;
        if (count_ff == `MCCT_ONE16) begin
          eoc      = 1'b1;
          nxt_down = 1'b0;
        end
      end
    end
  end

  wire cycle_end = step & eoc;

  // counter, prescaler and timer control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_ff <= 2'h0;
      timer_run_enable_ff    <= 1'b0;
      count_mode_select_ff   <= 2'h0;
      div_buf_ff             <= 3'h0;
      div_act_ff             <= 3'h0;
      count_ff               <= `MCCT_ZERO16;
      reload_ff              <= `MCCT_ZERO16;
      down_ff                <= 1'b0;
      pre_cnt_ff             <= 7'h00;
      ext_prev_ff            <= 1'b0;
      step_d_ff              <= 1'b0;
    end else begin
      ext_prev_ff <= external_timer_input;
      step_d_ff   <= step | over;
      // prescaler only runs while enabled, so a start is aligned
      if (timer_run_enable_ff)
        pre_cnt_ff <= pre_cnt_ff + 7'h01;
      else
        pre_cnt_ff <= 7'h00;
      if (wr_acc && paddr == `MCCT_A_CTRL0)
        clock_source_select_ff <= pwdata[`MCCT_CLKSRC_HI:`MCCT_CLKSRC_LO];
      if (wr_acc && paddr == `MCCT_A_CTRL1) begin
        timer_run_enable_ff  <= pwdata[`MCCT_RUN_BIT];
        count_mode_select_ff <= pwdata[`MCCT_MODE_HI:`MCCT_MODE_LO];
        div_buf_ff           <= pwdata[`MCCT_DIV_HI:`MCCT_DIV_LO];
        if (!timer_run_enable_ff)
          div_act_ff <= pwdata[`MCCT_DIV_HI:`MCCT_DIV_LO];
      end else if (cycle_end) begin
        div_act_ff <= div_buf_ff;
      end
      if (wr_acc && paddr == `MCCT_A_RELOAD)
        reload_ff <= pwdata[15:0];
      // software write to count wins over stepping
      if (wr_acc && paddr == `MCCT_A_COUNT) begin
        count_ff <= pwdata[15:0];
      end else if (over) begin
        count_ff <= `MCCT_ZERO16;
        down_ff  <= 1'b0;
      end else if (step) begin
        count_ff <= nxt_count;
        down_ff  <= nxt_down;
      end
    end
  end

  // per-channel events
  reg [3:0] match;
  reg [3:0] capt;
  reg [3:0] ev;
  integer   i, j;

  always @* begin
    match = 4'h0;
    capt  = 4'h0;
    for (j = 0; j < `MCCT_NCH; j = j + 1) begin
      match[j] = step_d_ff & channel_on_ff[j] &
                 (ch_mode_ff[2*j +: 2] != `MCCT_CM_CAPT) &
                 (count_ff == cmp_act_ff[16*j +: 16]);
      // rising edge when polarity 0, falling when 1
      capt[j]  = channel_on_ff[j] & (ch_mode_ff[2*j +: 2] == `MCCT_CM_CAPT) &
                 (channel_polarity_ff[j] ? (cin_prev_ff[j] & ~ch_in[j])
                                         : (~cin_prev_ff[j] & ch_in[j]));
    end
    ev = match | capt;
  end

  // channel state, outputs and requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on_ff         <= 4'h0;
      channel_polarity_ff   <= 4'h0;
      ch_mode_ff            <= 8'h00;
      cmp_buf_ff            <= 64'h0;
      cmp_act_ff            <= 64'h0;
      pwm_lvl_ff            <= 4'h0;
      cin_prev_ff           <= 4'h0;
      channel_event_flag_ff <= 4'h0;
      timer_flag_ff         <= 1'b0;
      channel_output        <= 4'h0;
      channel_irq           <= 4'h0;
      timer_irq             <= 1'b0;
      dma_req               <= 4'h0;
    end else begin
      cin_prev_ff <= ch_in;
      channel_irq <= ev;
      timer_irq   <= cycle_end;
      // hardware set wins over a same-cycle clear
      if (wr_acc && paddr == `MCCT_A_STATUS) begin
        channel_event_flag_ff <= (channel_event_flag_ff & ~pwdata[3:0]) | ev;
        timer_flag_ff <= (timer_flag_ff & ~pwdata[`MCCT_ST_TIMER]) | cycle_end;
      end else begin
        channel_event_flag_ff <= channel_event_flag_ff | ev;
        timer_flag_ff         <= timer_flag_ff | cycle_end;
      end
      for (i = 0; i < `MCCT_NCH; i = i + 1) begin
        // buffered compare value loads at end of cycle or when idle
        if (wr_val && widx == i) begin
          cmp_buf_ff[16*i +: 16] <= pwdata[15:0];
          if (!timer_run_enable_ff)
            cmp_act_ff[16*i +: 16] <= pwdata[15:0];
        end else if (capt[i]) begin
          cmp_act_ff[16*i +: 16] <= count_ff;
          cmp_buf_ff[16*i +: 16] <= count_ff;
        end else if (cycle_end) begin
          cmp_act_ff[16*i +: 16] <= cmp_buf_ff[16*i +: 16];
        end
        if (wr_ctl && widx == i) begin
          channel_on_ff[i]       <= pwdata[`MCCT_CH_ON];
          channel_polarity_ff[i] <= pwdata[`MCCT_CH_POL];
          ch_mode_ff[2*i +: 2]   <= pwdata[`MCCT_CH_MHI:`MCCT_CH_MLO];
        end else if (match[i] && ch_mode_ff[2*i +: 2] == `MCCT_CM_ONESHOT) begin
          channel_on_ff[i] <= 1'b0;
        end
        // pwm level restarts at polarity while channel is off
        if (!channel_on_ff[i])
          pwm_lvl_ff[i] <= channel_polarity_ff[i];
        else if (match[i])
          pwm_lvl_ff[i] <= is_mod ? ~channel_polarity_ff[i] : ~pwm_lvl_ff[i];
        else if (step_d_ff && is_mod && count_ff == `MCCT_ZERO16)  // wrap seen with the lag of a match
          pwm_lvl_ff[i] <= channel_polarity_ff[i];
        case (ch_mode_ff[2*i +: 2])
          `MCCT_CM_ONESHOT,
          `MCCT_CM_CONT: channel_output[i] <= match[i] ? ~channel_polarity_ff[i]
                                                      : channel_polarity_ff[i];
          `MCCT_CM_PWM:  channel_output[i] <= pwm_lvl_ff[i];
          default:       channel_output[i] <= channel_polarity_ff[i];
        endcase
        // request drops on ack or disable; a new event still wins
        if (ev[i])
          dma_req[i] <= 1'b1;
        else if (dma_ack[i] || !channel_on_ff[i])
          dma_req[i] <= 1'b0;
      end
    end
  end

  // read mux
  reg [31:0] nxt_rdata;
  reg        nxt_err;

  always @* begin
    nxt_rdata = `MCCT_ZERO32;
    nxt_err   = 1'b0;
    case (paddr & 8'hf0)
      8'h00: begin
        case (paddr)
          `MCCT_A_CTRL0:  nxt_rdata[`MCCT_CLKSRC_HI:`MCCT_CLKSRC_LO] = clock_source_select_ff;
          `MCCT_A_CTRL1: begin
            nxt_rdata[`MCCT_RUN_BIT]              = timer_run_enable_ff;
            nxt_rdata[`MCCT_MODE_HI:`MCCT_MODE_LO] = count_mode_select_ff;
            nxt_rdata[`MCCT_DIV_HI:`MCCT_DIV_LO]   = div_buf_ff;
          end
          `MCCT_A_COUNT:  nxt_rdata[15:0] = count_ff;
          `MCCT_A_RELOAD: nxt_rdata[15:0] = reload_ff;
          default:        nxt_err = 1'b1;
        endcase
      end
      8'h10: begin
        if (paddr == `MCCT_A_STATUS) begin
          nxt_rdata[3:0]           = channel_event_flag_ff;
          nxt_rdata[`MCCT_ST_TIMER] = timer_flag_ff;
          nxt_rdata[11:8]          = dma_req;
        end else begin
          nxt_err = 1'b1;
        end
      end
      `MCCT_A_CHCTL: begin
        nxt_rdata[`MCCT_CH_ON]              = channel_on_ff[widx];
        nxt_rdata[`MCCT_CH_POL]             = channel_polarity_ff[widx];
        nxt_rdata[`MCCT_CH_MHI:`MCCT_CH_MLO] = ch_mode_ff[2*widx +: 2];
      end
      `MCCT_A_CHVAL: nxt_rdata[15:0] = cmp_act_ff[16*widx +: 16];
      default: nxt_err = 1'b1;
    endcase
    if (paddr[1:0] != 2'h0)
      nxt_err = 1'b1;
  end

  // one wait-free access phase: ready rises the cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `MCCT_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & nxt_err;
      if (setup && !pwrite)
        prdata <= nxt_err ? `MCCT_ZERO32 : nxt_rdata;  // refused reads return zero
    end
  end

endmodule // mcct_top
